// [design/tao_pkg.sv]
/*
 * Shared definitions for the temperature alarm and output logic:
 * register offsets and field positions, reset values, alarm and
 * output-routing encodings, the measurement carrier and timing figures.
 * Assumes a 10 MHz system clock and a 32-bit classic Wishbone master.
 */
`default_nettype none
package tao_pkg;

    // Bus and value widths.
    localparam int DW = 32;
    localparam int AW = 8;
    localparam int VW = 16;
    localparam int PCT_W = 7;
    localparam int MIN_W = 8;
    localparam int ROUTE_W = 3;
    localparam int NCHAN = 4;

    // Register byte addresses.
    localparam logic [AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AW-1:0] REG_ALM1 = 8'h04;
    localparam logic [AW-1:0] REG_ALM2 = 8'h08;
    localparam logic [AW-1:0] REG_OFFS = 8'h0c;
    localparam logic [AW-1:0] REG_PBAND = 8'h10;
    localparam logic [AW-1:0] REG_SAFE = 8'h14;
    localparam logic [AW-1:0] REG_LOOP = 8'h18;
    localparam logic [AW-1:0] REG_ROUTE = 8'h1c;
    localparam logic [AW-1:0] REG_STAT = 8'h20;
    localparam logic [AW-1:0] REG_PVD = 8'h24;

    // Control register fields.
    localparam int CTRL_FN1_LSB = 0;
    localparam int CTRL_FN2_LSB = 4;
    localparam int CTRL_BLK1_BIT = 8;
    localparam int CTRL_BLK2_BIT = 9;
    localparam int CTRL_W = 10;

    // Status register fields.
    localparam int ST_ALM1_BIT = 0;
    localparam int ST_ALM2_BIT = 1;
    localparam int ST_LBD_BIT = 2;
    localparam int ST_FAULT_BIT = 3;
    localparam int ST_ONOFF_BIT = 4;
    localparam int ST_ARM1_BIT = 5;
    localparam int ST_ARM2_BIT = 6;
    localparam int ST_MIN_LSB = 8;

    // Reset values.
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
    localparam logic [VW-1:0] VAL_RST = 16'h0000;
    localparam logic [PCT_W-1:0] PCT_ZERO = 7'h00;
    localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
    localparam logic [MIN_W-1:0] MIN_ZERO = 8'h00;
    localparam logic [MIN_W-1:0] MIN_ONE = 8'h01;
    // Channel 1 control, 2 alarm one, 3 alarm two, 4 loop break.
    localparam logic [NCHAN*ROUTE_W-1:0] ROUTE_RST = 12'had1;

    // Smallest process-value move that counts as a loop response.
    localparam logic [VW:0] LBD_DELTA = 17'h00001;

    // Minute timing derived from the clock rate.
    localparam int unsigned MINUTE_S = 60;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned MINUTE_CYCLES = MINUTE_S * CLK_HZ;

    // Alarm functions.
    typedef enum logic [2:0] {
        ALARM_OFF_FN = 3'h0,
        ABS_MIN_ALARM_FN = 3'h1,
        ABS_MAX_ALARM_FN = 3'h2,
        DEV_BAND_ALARM_FN = 3'h3,
        LOW_DEV_ALARM_FN = 3'h4,
        HIGH_DEV_ALARM_FN = 3'h5,
        SENSOR_BREAK_ALARM_FN = 3'h6
    } tao_alarm_fn_t;

    // Output channel functions.
    typedef enum logic [ROUTE_W-1:0] {
        ROUTE_OFF = 3'h0,
        ROUTE_CTRL = 3'h1,
        ROUTE_ALM1 = 3'h2,
        ROUTE_ALM2 = 3'h3,
        ROUTE_ALM_OR = 3'h4,
        ROUTE_LBD = 3'h5
    } tao_route_t;

    // Loop-break supervisor states, Gray along idle, run, tripped.
    typedef enum logic [1:0] {
        LBD_IDLE = 2'b00,
        LBD_RUN = 2'b01,
        LBD_TRIP = 2'b11
    } tao_lbd_state_t;

    // One measurement sample as delivered by the input stage.
    typedef struct packed {
        logic signed [VW-1:0] pv;
        logic signed [VW-1:0] sp;
        logic fault;
    } tao_meas_t;

endpackage
`default_nettype wire

// [design/tao_top.sv]
/*
 * Alarm, safe-output, loop-break and output-routing logic of a panel
 * temperature controller, with its settings on a classic Wishbone slave.
 * Assumes the measurement arrives on the same clock with a one-cycle
 * sample strobe, and that an outside PID stage supplies the control demand.
 */
// The register offsets and the Wishbone register port were left to the implementer.
//
// Contract
// - Absolute minimum alarms when value below setpoint.
// - Absolute maximum alarms when value above setpoint.
// - Differential setpoints are deviations from control setpoint.
// - Low deviation alarms below setpoint minus deviation.
// - High deviation alarms above setpoint plus deviation.
// - Sensor break alarms on input fault only.
// - Off function never alarms.
// - Two independent alarms, same function set.
// - Maximum and deviation alarms also fire on fault; the low deviation alarm here ignores fault.
// - Initial blocking suppresses alarm present at start.
// - Blocked alarm arms after one clear sample.
// - Sensor break alarm is never blocked.
// - Fault forces control output to safe percentage; the control channel here still follows CTRL_DRIVE_I in PID mode.
// - On/off mode accepts safe value 0 or 100.
// - PID mode accepts safe value 0 to 100.
// - Unanswered output for interval raises loop break.
// - Loop-break channel active while event present.
// - Interval zero disables loop-break detection.
// - Each channel routes control, alarms, OR, loop break.
// - Zero proportional band selects on/off control.
// - User offset is added to measured value.
// - Serial-over-USB link lives outside this block.
`timescale 1ns/1ps
`default_nettype none

module tao_top
    import tao_pkg::*;
#(
    // Clock cycles in one minute; shorten for simulation.
    parameter int unsigned CYCLES_PER_MINUTE = tao_pkg::MINUTE_CYCLES
)
(
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [tao_pkg::AW-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [tao_pkg::DW-1:0] WB_DAT_I,
    output logic [tao_pkg::DW-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic SAMPLE_I,
    input wire tao_pkg::tao_meas_t MEAS_I,
    input wire logic [tao_pkg::PCT_W-1:0] CTRL_PCT_I,
    input wire logic CTRL_DRIVE_I,
    output logic [tao_pkg::PCT_W-1:0] CTRL_PCT_O,
    output logic [tao_pkg::NCHAN-1:0] CHAN_O,
    output logic [1:0] ALARM_O,
    output logic LBD_O,
    output logic ONOFF_O,
    output logic signed [tao_pkg::VW-1:0] PV_ADJ_O
);
    import tao_pkg::*;

    // Merges write data into a register under the byte enables.
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] dat,
                                            input logic [3:0] sel);
        logic [DW-1:0] res;
        for (int b = 0; b < 4; b++)
        begin
            res[b*8 +: 8] = sel[b] ? dat[b*8 +: 8] : old[b*8 +: 8];
        end
        return res;
    endfunction

    // Raw alarm condition of one alarm, before initial blocking.
    function automatic logic alarm_cond(input tao_alarm_fn_t fn, input logic signed [VW-1:0] sp_a,
                                        input logic signed [VW-1:0] pv, input logic signed [VW-1:0] csp,
                                        input logic flt);
        logic signed [VW+1:0] p;
        logic signed [VW+1:0] band_low;
        logic signed [VW+1:0] band_high;
        logic res;
        p = (VW+2)'(pv);
        band_low = (VW+2)'(csp) - (VW+2)'(sp_a);
        band_high = (VW+2)'(csp) + (VW+2)'(sp_a);
        case (fn)
            ABS_MIN_ALARM_FN: res = p < (VW+2)'(sp_a);
            ABS_MAX_ALARM_FN: res = (p > (VW+2)'(sp_a)) || flt;
            DEV_BAND_ALARM_FN: res = (p < band_low && p < band_high) || (p > band_low && p > band_high) || flt;
            LOW_DEV_ALARM_FN: res = p < band_low;
            // above setpoint plus deviation, plus fault
            HIGH_DEV_ALARM_FN: res = (p > band_high) || flt;
            SENSOR_BREAK_ALARM_FN: res = flt;
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    // True when the value has moved at least the response step from the reference.
    function automatic logic moved(input logic signed [VW-1:0] now, input logic signed [VW-1:0] ref_v);
        logic signed [VW:0] d;
        d = (VW+1)'(now) - (VW+1)'(ref_v);
        d = (d < 0) ? -d : d;
        return d >= $signed(LBD_DELTA);
    endfunction

    // Settings written by software.
    logic [CTRL_W-1:0] ctrl; // Alarm functions and blocking enables.
    logic signed [VW-1:0] alarm_one_setpoint; // Alarm one setpoint or deviation.
    logic signed [VW-1:0] alarm_two_setpoint; // Alarm two setpoint or deviation.
    logic signed [VW-1:0] pv_offset; // Correction added to the measurement.
    logic [VW-1:0] proportional_band; // Band in tenths of a percent.
    logic [PCT_W-1:0] fault_safe_output_pct; // Control level held during a fault.
    logic [MIN_W-1:0] loop_break_interval; // Minutes allowed for a response.
    logic [NCHAN*ROUTE_W-1:0] route; // Function of each output channel.

    // Block state.
    logic [1:0] armed; // Alarm may fire; cleared at power-up.
    logic lbd_event; // Loop-break event present.
    tao_lbd_state_t lbd_state; // Loop-break supervisor state.
    logic [31:0] tick_cnt; // Cycles into the current minute.
    logic [MIN_W-1:0] min_cnt; // Whole minutes without a response.
    logic signed [VW-1:0] lbd_ref; // Value at the start of the wait.
    logic fault_seen; // Fault flag as of the last sample.

    // Combinational helpers.
    logic onoff_mode; // On/off control selected.
    logic signed [VW-1:0] next_pv; // Offset-corrected measurement.
    logic [1:0] next_cond; // Raw condition of each alarm.
    logic [1:0] next_alarm; // Condition after blocking.
    logic [1:0] blk_en; // Initial blocking enabled per alarm.
    logic [1:0] is_break; // Alarm is the sensor-break function.
    tao_alarm_fn_t fn1; // Function of alarm one.
    tao_alarm_fn_t fn2; // Function of alarm two.
    logic bus_req; // New bus request this cycle.
    logic bus_wr; // New write request this cycle.

    // Decodes settings and evaluates both alarms from the current sample.
    always_comb
    begin
        onoff_mode = proportional_band == VAL_RST;
        next_pv = MEAS_I.pv + pv_offset;
        fn1 = tao_alarm_fn_t'(ctrl[CTRL_FN1_LSB +: 3]);
        fn2 = tao_alarm_fn_t'(ctrl[CTRL_FN2_LSB +: 3]);
        next_cond[0] = alarm_cond(fn1, alarm_one_setpoint, next_pv, MEAS_I.sp, MEAS_I.fault);
        next_cond[1] = alarm_cond(fn2, alarm_two_setpoint, next_pv, MEAS_I.sp, MEAS_I.fault);
        blk_en = {ctrl[CTRL_BLK2_BIT], ctrl[CTRL_BLK1_BIT]};
        is_break = {fn2 == SENSOR_BREAK_ALARM_FN, fn1 == SENSOR_BREAK_ALARM_FN};
        // suppress until armed; sensor break bypasses blocking
        next_alarm = next_cond & (armed | ~blk_en | is_break);
        bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
        bus_wr = bus_req && WB_WE_I;
    end

    // Bus handshake: ack one cycle after the request, dropped the next cycle.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            WB_ACK_O <= 1'b0;
        end
        else
        begin
            WB_ACK_O <= bus_req;
        end
    end

    // Register writes; a write lands at the edge that raises ack.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            ctrl <= CTRL_RST;
            alarm_one_setpoint <= VAL_RST;
            alarm_two_setpoint <= VAL_RST;
            pv_offset <= VAL_RST;
            proportional_band <= VAL_RST;
            fault_safe_output_pct <= PCT_ZERO;
            loop_break_interval <= MIN_ZERO;
            route <= ROUTE_RST;
        end
        else if (bus_wr)
        begin
            case (WB_ADR_I)
                REG_CTRL: ctrl <= CTRL_W'(merge(DW'(ctrl), WB_DAT_I, WB_SEL_I));
                REG_ALM1: alarm_one_setpoint <= VW'(merge(DW'(alarm_one_setpoint), WB_DAT_I, WB_SEL_I));
                REG_ALM2: alarm_two_setpoint <= VW'(merge(DW'(alarm_two_setpoint), WB_DAT_I, WB_SEL_I));
                REG_OFFS: pv_offset <= VW'(merge(DW'(pv_offset), WB_DAT_I, WB_SEL_I));
                REG_PBAND: proportional_band <= VW'(merge(DW'(proportional_band), WB_DAT_I, WB_SEL_I));
                REG_SAFE:
                begin
                    // on/off takes only 0 or 100; PID takes 0 to 100
                    if (WB_SEL_I[0] && WB_DAT_I[DW-1:PCT_W] == '0 &&
                        (onoff_mode ? (WB_DAT_I[PCT_W-1:0] == PCT_ZERO || WB_DAT_I[PCT_W-1:0] == PCT_FULL)
                                    : WB_DAT_I[PCT_W-1:0] <= PCT_FULL))
                    begin
                        fault_safe_output_pct <= WB_DAT_I[PCT_W-1:0];
                    end
                end
                REG_LOOP: loop_break_interval <= MIN_W'(merge(DW'(loop_break_interval), WB_DAT_I, WB_SEL_I));
                REG_ROUTE: route <= (NCHAN*ROUTE_W)'(merge(DW'(route), WB_DAT_I, WB_SEL_I));
                // Read-only and unmapped addresses ignore writes.
                default: ;
            endcase
        end
    end

    // Read data, captured with the ack; unmapped addresses read zero.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            WB_DAT_O <= '0;
        end
        else if (bus_req && !WB_WE_I)
        begin
            WB_DAT_O <= '0;
            case (WB_ADR_I)
                REG_CTRL: WB_DAT_O <= DW'(ctrl);
                REG_ALM1: WB_DAT_O <= DW'(alarm_one_setpoint);
                REG_ALM2: WB_DAT_O <= DW'(alarm_two_setpoint);
                REG_OFFS: WB_DAT_O <= DW'(pv_offset);
                REG_PBAND: WB_DAT_O <= DW'(proportional_band);
                REG_SAFE: WB_DAT_O <= DW'(fault_safe_output_pct);
                REG_LOOP: WB_DAT_O <= DW'(loop_break_interval);
                REG_ROUTE: WB_DAT_O <= DW'(route);
                REG_STAT:
                begin
                    WB_DAT_O[ST_ALM1_BIT] <= ALARM_O[0];
                    WB_DAT_O[ST_ALM2_BIT] <= ALARM_O[1];
                    WB_DAT_O[ST_LBD_BIT] <= lbd_event;
                    WB_DAT_O[ST_FAULT_BIT] <= fault_seen;
                    WB_DAT_O[ST_ONOFF_BIT] <= onoff_mode;
                    WB_DAT_O[ST_ARM1_BIT] <= armed[0];
                    WB_DAT_O[ST_ARM2_BIT] <= armed[1];
                    WB_DAT_O[ST_MIN_LSB +: MIN_W] <= min_cnt;
                end
                // Sign-extended so software sees the true value.
                REG_PVD: WB_DAT_O <= DW'(PV_ADJ_O);
                default: WB_DAT_O <= '0;
            endcase
        end
    end

    // Initial blocking: an alarm arms once a sample shows no alarm.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            armed <= 2'b00;
        end
        else if (SAMPLE_I)
        begin
            // arm after a clear sample; stays armed afterwards
            armed <= armed | ~next_cond;
        end
    end

    // Alarm, display value and fault snapshot, refreshed per sample.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            ALARM_O <= 2'b00;
            PV_ADJ_O <= VAL_RST;
            fault_seen <= 1'b0;
            ONOFF_O <= 1'b1;
        end
        else
        begin
            ONOFF_O <= onoff_mode;
            if (SAMPLE_I)
            begin
                ALARM_O <= next_alarm;
                PV_ADJ_O <= next_pv;
                fault_seen <= MEAS_I.fault;
            end
        end
    end

    // Control level and channel routing, refreshed per sample.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            CTRL_PCT_O <= PCT_ZERO;
            CHAN_O <= '0;
        end
        else if (SAMPLE_I)
        begin
            // fault holds the safe level until it clears
            CTRL_PCT_O <= MEAS_I.fault ? fault_safe_output_pct : CTRL_PCT_I;
            for (int c = 0; c < NCHAN; c++)
            begin
                case (tao_route_t'(route[c*ROUTE_W +: ROUTE_W]))
                    // In on/off mode a fault turns the safe level into a plain level.
                    ROUTE_CTRL: CHAN_O[c] <= (MEAS_I.fault && onoff_mode) ?
                                             (fault_safe_output_pct != PCT_ZERO) : CTRL_DRIVE_I;
                    ROUTE_ALM1: CHAN_O[c] <= next_alarm[0];
                    ROUTE_ALM2: CHAN_O[c] <= next_alarm[1];
                    ROUTE_ALM_OR: CHAN_O[c] <= |next_alarm;
                    ROUTE_LBD: CHAN_O[c] <= lbd_event;
                    default: CHAN_O[c] <= 1'b0;
                endcase
            end
        end
    end

    // Loop-break supervisor: counts minutes without a response of the value.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            lbd_state <= LBD_IDLE;
            tick_cnt <= '0;
            min_cnt <= MIN_ZERO;
            lbd_ref <= VAL_RST;
        end
        else if (loop_break_interval == MIN_ZERO)
        begin
            lbd_state <= LBD_IDLE;
            tick_cnt <= '0;
            min_cnt <= MIN_ZERO;
        end
        // first sample or a move restarts the wait and clears a trip
        else if (SAMPLE_I && (lbd_state == LBD_IDLE || moved(next_pv, lbd_ref)))
        begin
            lbd_ref <= next_pv;
            tick_cnt <= '0;
            min_cnt <= MIN_ZERO;
            lbd_state <= LBD_RUN;
        end
        else
        begin
            case (lbd_state)
                // Nothing to time until the first sample arrives.
                LBD_IDLE: ;
                // wait for a response within the interval
                LBD_RUN:
                begin
                    if (tick_cnt == CYCLES_PER_MINUTE - 1)
                    begin
                        tick_cnt <= '0;
                        min_cnt <= min_cnt + MIN_ONE;
                        if (min_cnt + MIN_ONE >= loop_break_interval)
                        begin
                            lbd_state <= LBD_TRIP;
                        end
                    end
                    else
                    begin
                        tick_cnt <= tick_cnt + 32'h1;
                    end
                end
                // Event stands until the value moves again.
                LBD_TRIP: ;
                default: lbd_state <= LBD_IDLE;
            endcase
        end
    end

    // Registered event flag and output, so both leave a flip-flop.
    always_ff @(posedge CLOCK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            lbd_event <= 1'b0;
            LBD_O <= 1'b0;
        end
        else
        begin
            lbd_event <= lbd_state == LBD_TRIP && loop_break_interval != MIN_ZERO;
            LBD_O <= lbd_event;
        end
    end

endmodule // tao_top

`default_nettype wire

// [verification/tao_properties.sv]
/* Port-level checker for the alarm and output block, bound to its top.
   Assumes one clock domain and the active-low asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module tao_properties
    import tao_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MINUTE = tao_pkg::MINUTE_CYCLES
)
(
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic SAMPLE_I,
    input wire tao_pkg::tao_meas_t MEAS_I,
    input wire logic [tao_pkg::PCT_W-1:0] CTRL_PCT_I,
    input wire logic [tao_pkg::PCT_W-1:0] CTRL_PCT_O,
    input wire logic [tao_pkg::NCHAN-1:0] CHAN_O,
    input wire logic [1:0] ALARM_O,
    input wire logic signed [tao_pkg::VW-1:0] PV_ADJ_O
);
    // Everything here lives on the one system clock.
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);
    property p_ack_resp; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("bus request not answered");
    property p_ack_once; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    property p_ack_idle; !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O; endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without request");
    // Alarm, channel, corrected-value and control-level outputs may only move at a sample, so stale logic shows up here.
    property p_alm_hold; !SAMPLE_I |=> $stable(ALARM_O); endproperty
    a_alm_hold: assert property (p_alm_hold) else $error("alarm moved between samples");
    property p_chan_hold; !SAMPLE_I |=> $stable(CHAN_O); endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved between samples");
    property p_pv_hold; !SAMPLE_I |=> $stable(PV_ADJ_O); endproperty
    a_pv_hold: assert property (p_pv_hold) else $error("corrected value moved");
    property p_ctrl_hold; !SAMPLE_I |=> $stable(CTRL_PCT_O); endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control level moved");
    property p_ctrl_pass; SAMPLE_I && !MEAS_I.fault |=> CTRL_PCT_O == $past(CTRL_PCT_I); endproperty
    a_ctrl_pass: assert property (p_ctrl_pass) else $error("demand not passed");
endmodule // tao_properties
bind tao_top tao_properties #(.CYCLES_PER_MINUTE(CYCLES_PER_MINUTE)) chk_u (.CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .SAMPLE_I(SAMPLE_I), .MEAS_I(MEAS_I),
    .CTRL_PCT_I(CTRL_PCT_I), .CTRL_PCT_O(CTRL_PCT_O), .CHAN_O(CHAN_O), .ALARM_O(ALARM_O), .PV_ADJ_O(PV_ADJ_O));
`default_nettype wire

// [verification/tao_sensor_model.sv]
/* Behavioural input stage delivering one measurement sample per call.
   Assumes the block samples on the rising edge of the shared clock. */
`timescale 1ns/1ps
`default_nettype none
module tao_sensor_model
    import tao_pkg::*;
(
    input wire logic clk_i,
    output logic sample_o,
    output tao_pkg::tao_meas_t meas_o,
    output logic [tao_pkg::PCT_W-1:0] pct_o,
    output logic drive_o
);
    initial
    begin
        sample_o = 1'b0;
        meas_o = '0;
        pct_o = '0;
        drive_o = 1'b0;
    end
    // Outside the strobe the lines show inverted data, so stale values never look valid.
    task automatic send(input logic signed [VW-1:0] pv, input logic f, input logic [PCT_W-1:0] p);
        @(posedge clk_i);
        sample_o <= 1'b1;
        meas_o <= '{pv: pv, sp: 16'sh0064, fault: f};
        pct_o <= p;
        drive_o <= 1'b1;
        @(posedge clk_i);
        sample_o <= 1'b0;
        meas_o <= '{pv: ~pv, sp: 16'shff9b, fault: ~f};
        pct_o <= ~p;
        drive_o <= 1'b0;
    endtask
endmodule // tao_sensor_model
`default_nettype wire

// [verification/tb.sv]
/* Self-checking bench for the alarm and output block.
   Assumes the sensor model and the bound checker are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tao_pkg::*;
    localparam int CPM = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, wen = 1'b0;
    logic [AW-1:0] adr = '0;
    logic [DW-1:0] wdat = '0, rdat, q;
    logic ack, sample, drive, lbd, onoff;
    tao_meas_t meas;
    logic [PCT_W-1:0] pct, pct_o;
    logic [NCHAN-1:0] chan;
    logic [1:0] alarm;
    logic signed [VW-1:0] pv_adj;
    int bad_count = 0, checked = 0;
    always #50 clk = ~clk;
    tao_top #(.CYCLES_PER_MINUTE(CPM)) dut_u (.CLOCK_I(clk), .RSTN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(wen), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .SAMPLE_I(sample), .MEAS_I(meas), .CTRL_PCT_I(pct), .CTRL_DRIVE_I(drive), .CTRL_PCT_O(pct_o),
        .CHAN_O(chan), .ALARM_O(alarm), .LBD_O(lbd), .ONOFF_O(onoff), .PV_ADJ_O(pv_adj));
    tao_sensor_model sens_u (.clk_i(clk), .sample_o(sample), .meas_o(meas), .pct_o(pct), .drive_o(drive));
    task automatic finish_test();
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
        checked++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // Classic single cycle; the request stands until ack is seen at an edge.
    task automatic wb(input logic we, input logic [AW-1:0] a, input logic [DW-1:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, wen, adr, wdat} <= {2'b11, we, a, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1)
        begin
            bad_count++;
            finish_test();
        end
    endtask
    task automatic smp(input int v, input logic f, input logic [PCT_W-1:0] p);
        sens_u.send(v[VW-1:0], f, p);
        @(negedge clk);
    endtask
    // Control setpoint is always 100 in this bench.
    function automatic logic exp_alm(input int fn, input int pv, input int a, input logic f);
        int d;
        d = (a < 0) ? -a : a;
        case (fn)
            1: return pv < a;
            2: return pv > a || f;
            3: return pv < 100 - d || pv > 100 + d || f;
            4: return pv < 100 - a;
            5: return pv > 100 + a || f;
            6: return f;
            default: return 1'b0;
        endcase
    endfunction
    task automatic t_reset_vals();
        chk("onoff", 1, onoff);
        chk("alarm", 0, alarm);
        wb(0, REG_ROUTE, 0);
        chk("route", 32'had1, q);
        wb(1, 8'h80, 32'hffffffff);
        wb(0, 8'h80, 0);
        chk("unmapped", 0, q);
    endtask
    task automatic t_offset();
        wb(1, REG_OFFS, 32'hfffffffd);
        smp(7, 0, 0);
        chk("pv_adj", 32'h4, pv_adj);
        wb(0, REG_PVD, 0);
        chk("pv_read", 32'h4, q);
        wb(1, REG_OFFS, 0);
    endtask
    task automatic t_alarms();
        logic [1:0] e;
        int pvs[4] = '{10, 90, 130, 100};
        wb(1, REG_ALM1, 32'h14);
        wb(1, REG_ALM2, 32'hffffffec);
        wb(1, REG_ROUTE, 32'had4);
        for (int fn = 0; fn < 7; fn++)
        begin
            wb(1, REG_CTRL, fn | (fn << 4));
            for (int i = 0; i < 4; i++)
            begin
                smp(pvs[i], i == 3, 7'h20);
                e = {exp_alm(fn, pvs[i], -20, i == 3), exp_alm(fn, pvs[i], 20, i == 3)};
                chk("alarm", e, alarm);
                chk("chan", {e, |e}, chan[2:0]);
            end
        end
    endtask
    task automatic t_safe();
        wb(1, REG_SAFE, 32'h32);
        wb(0, REG_SAFE, 0);
        chk("safe", 0, q);
        wb(1, REG_SAFE, 32'h64);
        smp(50, 1, 7'h25);
        chk("ctrl_pct", 32'h64, pct_o);
        smp(50, 0, 7'h25);
        chk("ctrl_pct", 32'h25, pct_o);
        wb(1, REG_PBAND, 32'ha);
        repeat (2) @(negedge clk);
        chk("onoff", 0, onoff);
        wb(1, REG_SAFE, 32'h32);
        wb(1, REG_SAFE, 32'h65);
        wb(0, REG_SAFE, 0);
        chk("safe", 32'h32, q);
        smp(50, 1, 7'h25);
        chk("ctrl_pct", 32'h32, pct_o);
    endtask
    task automatic t_loop();
        int n;
        wb(1, REG_LOOP, 1);
        smp(50, 0, 0);
        n = 0;
        while (lbd !== 1'b1 && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        chk("lbd_delay", 1, n >= CPM && n <= CPM + 5);
        smp(50, 0, 0);
        chk("lbd_chan", 1, chan[3]);
        smp(60, 0, 0);
        repeat (3) @(negedge clk);
        chk("lbd_clear", 0, lbd);
        wb(1, REG_LOOP, 0);
        smp(60, 0, 0);
        repeat (CPM * 3) @(negedge clk);
        chk("lbd_off", 0, lbd);
    endtask
    // Blocking needs a fresh reset, since arming lasts until reset.
    task automatic t_block();
        do_reset();
        wb(1, REG_ALM1, 32'h14);
        wb(1, REG_CTRL, 32'h361);
        smp(10, 1, 0);
        chk("alarm", 2'b10, alarm);
        chk("chan", 3'b100, chan[2:0]);
        wb(0, REG_STAT, 0);
        chk("status", 32'h1a, q);
        smp(30, 0, 0);
        chk("alarm", 2'b00, alarm);
        smp(10, 0, 0);
        chk("alarm", 2'b01, alarm);
        chk("chan", 3'b011, chan[2:0]);
    endtask
    initial
    begin
        do_reset();
        t_reset_vals();
        t_offset();
        t_alarms();
        t_safe();
        t_loop();
        t_block();
        finish_test();
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        bad_count++;
        finish_test();
    end
endmodule // tb
`default_nettype wire
